// file: hdl/ldc_channel.v
// Purpose: one lamp channel: behavior sequencer and pwm with polarity/mirror
// Assumes: pwm_tick is a one-cycle enable, duty values are 0..255 of 255
// Notes:   actuate is the already resolved touch/host request
`timescale 1ns/1ps
`include "ldc_map.vh"
module ldc_channel
(
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       pwm_tick,
  input  wire       actuate,
  input  wire [1:0] behavior,
  input  wire       polarity,
  input  wire       mirror,
  input  wire [7:0] min_duty,
  input  wire [7:0] max_duty,
  output reg        pin_level,
  output reg        active
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_UP    = 2'h1;
  localparam ST_DOWN  = 2'h2;
  localparam ST_HOLD  = 2'h3;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] level;
  reg  [7:0] pwm_cnt;
  reg  [2:0] pulses;
  reg        actuate_d;
  reg        run;
  wire       rise = actuate & ~actuate_d;
  wire       fall = ~actuate & actuate_d;
  wire       at_max = (level >= max_duty) || (max_duty - level < `LDC_RAMP_STEP);
  wire       at_min = (level <= min_duty) || (level - min_duty < `LDC_RAMP_STEP);
  wire [7:0] eff_duty;
  wire       duty_on;

  // level is the low-time of an inverted pin; mirror re-references to 100%
  assign eff_duty = mirror ? (8'hFF - level) : level;
  assign duty_on  = (pwm_cnt < eff_duty);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:  if (run) next_state = ST_UP;
      ST_UP:    if (at_max) next_state = (behavior == `LDC_BEH_DIRECT) ? ST_HOLD : ST_DOWN;
      ST_DOWN:  if (at_min) next_state = run ? ST_UP : ST_IDLE;
      ST_HOLD:  if (!run) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state     <= ST_IDLE;
      level     <= 8'h00;
      pwm_cnt   <= 8'h00;
      pulses    <= 3'h0;
      actuate_d <= 1'b0;
      run       <= 1'b0;
      pin_level <= 1'b1;
      active    <= 1'b0;
    end
    else
    begin
      actuate_d <= actuate;
      // start and stop triggers per behavior
      case (behavior)
        `LDC_BEH_DIRECT, `LDC_BEH_BREATHE:
          run <= actuate;
        `LDC_BEH_PULSE1:
          if ((rise || fall) && pulses == 3'h0)
          begin
            pulses <= `LDC_PULSE_COUNT;
            run    <= 1'b1;
          end
        default:
          if (rise)
          begin
            run    <= 1'b1;
            pulses <= 3'h0;
          end
          else if (fall)
            pulses <= `LDC_PULSE_COUNT;
      endcase
      // direct follows its request at once; ramps step once per pwm period
      if (behavior == `LDC_BEH_DIRECT)
        level <= actuate ? max_duty : min_duty;
      if (pwm_tick)
      begin
        pwm_cnt <= (pwm_cnt == 8'hFE) ? 8'h00 : pwm_cnt + 8'h01;
        if (pwm_cnt == 8'hFE)
        begin
          state <= next_state;
          if (behavior != `LDC_BEH_DIRECT)
          begin
            if (state == ST_UP && !at_max)
              level <= level + `LDC_RAMP_STEP;
            else if (state == ST_DOWN && !at_min)
              level <= level - `LDC_RAMP_STEP;
            else if (state == ST_IDLE)
              level <= min_duty;
          end
          if (state == ST_DOWN && at_min && pulses != 3'h0 && behavior != `LDC_BEH_BREATHE)
          begin
            pulses <= pulses - 3'h1;
            if (pulses == 3'h1)
              run <= 1'b0;
          end
        end
      end
      active    <= run;
      // duty fraction drives low when inverted, high when non-inverted
      pin_level <= polarity ? duty_on : ~duty_on;
    end
  end

endmodule // ldc_channel

// file: hdl/ldc_map.vh
// Purpose: register offsets, field positions, reset values and timing for ldc
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   none
`ifndef LDC_MAP_VH
`define LDC_MAP_VH

`define LDC_ADDR_LINK      8'h72
`define LDC_ADDR_POLARITY  8'h73
`define LDC_ADDR_DRIVE     8'h74
`define LDC_ADDR_TRANS     8'h77
`define LDC_ADDR_MIRROR    8'h79
`define LDC_ADDR_MIN_DUTY  8'h86
`define LDC_ADDR_MAX_DUTY  8'h87
`define LDC_ADDR_BEHAVIOR  8'h81
`define LDC_ADDR_CONFIG    8'h88
`define LDC_ADDR_STATUS    8'h89

`define LDC_RST_DRIVE      2'h0
`define LDC_RST_TRANS      2'h0
`define LDC_RST_MIRROR     2'h0
`define LDC_RST_BEHAVIOR   4'h0
`define LDC_RST_POLARITY   2'h0
`define LDC_RST_LINK       2'h0
`define LDC_RST_MIN_DUTY   8'h00
`define LDC_RST_MAX_DUTY   8'hFF

`define LDC_CFG_INV_BIT    0
`define LDC_CFG_BLKMIR_BIT 1

`define LDC_BEH_DIRECT     2'h0
`define LDC_BEH_PULSE1     2'h1
`define LDC_BEH_PULSE2     2'h2
`define LDC_BEH_BREATHE    2'h3

`define LDC_PULSE_COUNT    3'h4
`define LDC_PWM_TICK_NS    1000
`define LDC_CLK_NS         10
`define LDC_PWM_TICK_CYC   (`LDC_PWM_TICK_NS / `LDC_CLK_NS)
// last count of the tick divider, one below the cycles per tick
`define LDC_PWM_TICK_LAST  7'h63
`define LDC_RAMP_STEP      8'h04

`endif

// file: hdl/ldc_top.v
// Purpose: two-channel lamp drive control with touch linking and host drive
// Assumes: touch inputs are asynchronous pins; one 100 MHz clock
// Notes:   read data valid one cycle after the read strobe
//
// Overview of operation
// - host drive register at 74h, reset 00h, bit1 second, bit0 first channel.
// - a linked channel ignores its host drive bit.
// - cleared bit gives minimum duty, set bit actuates to maximum duty.
// - polarity sets idle pin state; actuated behavior follows behavior field.
// - inverted and idle: pin low for minimum-duty fraction only.
// - inverted and actuated: ramp low-time from minimum toward maximum duty.
// - non-inverted: duty is relative to 100 percent.
// - link-transition register at 77h, reset 00h, one bit per channel.
// - transition bit clear: linking with host bit set and no touch toggles lamp.
// - transition and invert set: linking keeps lamp; later touches toggle it.
// - transition set, invert clear: linking keeps lamp; touches leave it unchanged.
// - mirror register at 79h, reset 00h, set references duty to 100 percent.
// - polarity write copies into mirror unless block-mirror-copy is set.
// - behavior register at 81h, reset 00h, fields bits 3:2 and 1:0.
// - behavior: direct, pulse count, pulse then count, breathe.
// - polarity clear inverts; polarity set non-inverting.
// - unlinked channel treats host bit 1 as touch, 0 as release.
`timescale 1ns/1ps
`include "ldc_map.vh"
module ldc_top
(
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       first_touch_input,
  input  wire       second_touch_input,
  output wire       first_lamp_pin,
  output wire       second_lamp_pin
);

  reg  [1:0] link_enable;
  reg  [1:0] channel_polarity;
  reg  [1:0] led_host_drive;
  reg  [1:0] linked_transition_control;
  reg  [1:0] duty_mirror_control;
  reg  [3:0] led_behavior_select;
  reg  [7:0] min_duty;
  reg  [7:0] max_duty;
  reg  [1:0] config_bits;
  reg  [6:0] tick_cnt;
  reg        pwm_tick;
  wire [1:0] pin_level;
  wire [1:0] ch_active;
  wire [1:0] touch_raw = {second_touch_input, first_touch_input};
  wire       inv_tran  = config_bits[`LDC_CFG_INV_BIT];

  localparam [6:0] TICK_LAST = `LDC_PWM_TICK_LAST;

  // pwm rate enable
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt <= 7'h00;
      pwm_tick <= 1'b0;
    end
    else
    begin
      pwm_tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 7'h00 : tick_cnt + 7'h01;
    end
  end

  // register writes
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_enable               <= `LDC_RST_LINK;
      channel_polarity          <= `LDC_RST_POLARITY;
      led_host_drive            <= `LDC_RST_DRIVE;
      linked_transition_control <= `LDC_RST_TRANS;
      duty_mirror_control       <= `LDC_RST_MIRROR;
      led_behavior_select       <= `LDC_RST_BEHAVIOR;
      min_duty                  <= `LDC_RST_MIN_DUTY;
      max_duty                  <= `LDC_RST_MAX_DUTY;
      config_bits               <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `LDC_ADDR_LINK)
        link_enable <= reg_wdata[1:0];
      else if (reg_addr == `LDC_ADDR_POLARITY)
      begin
        channel_polarity <= reg_wdata[1:0];
        if (!config_bits[`LDC_CFG_BLKMIR_BIT])
          duty_mirror_control <= reg_wdata[1:0];
      end
      else if (reg_addr == `LDC_ADDR_DRIVE)
        led_host_drive <= reg_wdata[1:0];
      else if (reg_addr == `LDC_ADDR_TRANS)
        linked_transition_control <= reg_wdata[1:0];
      else if (reg_addr == `LDC_ADDR_MIRROR)
        duty_mirror_control <= reg_wdata[1:0];
      else if (reg_addr == `LDC_ADDR_BEHAVIOR)
        led_behavior_select <= reg_wdata[3:0];
      else if (reg_addr == `LDC_ADDR_MIN_DUTY)
        min_duty <= reg_wdata;
      else if (reg_addr == `LDC_ADDR_MAX_DUTY)
        max_duty <= reg_wdata;
      else if (reg_addr == `LDC_ADDR_CONFIG)
        config_bits <= reg_wdata[1:0];
    end
  end

  // register reads, one cycle later
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `LDC_ADDR_LINK)
        reg_rdata <= {6'h00, link_enable};
      else if (reg_addr == `LDC_ADDR_POLARITY)
        reg_rdata <= {6'h00, channel_polarity};
      else if (reg_addr == `LDC_ADDR_DRIVE)
        reg_rdata <= {6'h00, led_host_drive};
      else if (reg_addr == `LDC_ADDR_TRANS)
        reg_rdata <= {6'h00, linked_transition_control};
      else if (reg_addr == `LDC_ADDR_MIRROR)
        reg_rdata <= {6'h00, duty_mirror_control};
      else if (reg_addr == `LDC_ADDR_BEHAVIOR)
        reg_rdata <= {4'h0, led_behavior_select};
      else if (reg_addr == `LDC_ADDR_MIN_DUTY)
        reg_rdata <= min_duty;
      else if (reg_addr == `LDC_ADDR_MAX_DUTY)
        reg_rdata <= max_duty;
      else if (reg_addr == `LDC_ADDR_CONFIG)
        reg_rdata <= {6'h00, config_bits};
      else if (reg_addr == `LDC_ADDR_STATUS)
        reg_rdata <= {4'h0, ch_active, pin_level};
      else
        reg_rdata <= 8'h00;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      reg  touch_s1;
      reg  touch_s2;
      reg  touch_s3;
      reg  touch;
      reg  touch_d;
      reg  link_d;
      reg  hold_mode;
      reg  hold_level;
      wire link_now;
      wire actuate;
      // linking now with host bit set, no touch, transition bit set
      assign link_now = link_enable[i] & ~link_d & led_host_drive[i] & ~touch
                        & linked_transition_control[i];
      // touch synchroniser: accept change when stages two and three agree
      always @(posedge clk_sys or negedge arst_n)
      begin
        if (!arst_n)
        begin
          touch_s1   <= 1'b0;
          touch_s2   <= 1'b0;
          touch_s3   <= 1'b0;
          touch      <= 1'b0;
          touch_d    <= 1'b0;
          link_d     <= 1'b0;
          hold_mode  <= 1'b0;
          hold_level <= 1'b0;
        end
        else
        begin
          touch_s1 <= touch_raw[i];
          touch_s2 <= touch_s1;
          touch_s3 <= touch_s2;
          if (touch_s2 == touch_s3)
            touch <= touch_s3;
          touch_d <= touch;
          link_d  <= link_enable[i];
          if (!link_enable[i])
            hold_mode <= 1'b0;
          else if (link_now)
          begin
            hold_mode  <= 1'b1;
            hold_level <= 1'b1;
          end
          else if (hold_mode && inv_tran && touch && !touch_d)
            hold_level <= ~hold_level;
        end
      end
      // clear transition bit: plain touch following, so the lamp drops
      // link_now keeps the lamp actuated in the very cycle of linking
      assign actuate = !link_enable[i] ? led_host_drive[i] :
                       link_now        ? 1'b1 :
                       hold_mode       ? hold_level : touch;
      ldc_channel u_ch
      (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .pwm_tick  (pwm_tick),
        .actuate   (actuate),
        .behavior  (led_behavior_select[2*i+1:2*i]),
        .polarity  (channel_polarity[i]),
        .mirror    (duty_mirror_control[i]),
        .min_duty  (min_duty),
        .max_duty  (max_duty),
        .pin_level (pin_level[i]),
        .active    (ch_active[i])
      );
    end
  endgenerate

  assign first_lamp_pin  = pin_level[0];
  assign second_lamp_pin = pin_level[1];

endmodule // ldc_top

// file: tb/ldc_lamps.sv
// Purpose: two lamps hanging on the lamp pins
// Assumes: lamp lit while its pin sinks current
// Notes:   none
`timescale 1ns/1ps
module ldc_lamps
(
  input  wire       first_lamp_pin,
  input  wire       second_lamp_pin,
  output wire [1:0] lamp_on
);
  assign lamp_on = {~second_lamp_pin, ~first_lamp_pin};
endmodule // ldc_lamps

// file: tb/ldc_properties.sv
// Purpose: register port properties of ldc_top
// Assumes: one clock, async active-low reset
// Notes:   bound after the module
`timescale 1ns/1ps
module ldc_properties
(
  input wire       clk_sys,
  input wire       arst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (reg_rd && (reg_addr == 8'h74 || reg_addr == 8'h77 ||
    reg_addr == 8'h79) |=> reg_rdata[7:2] == 6'h00) else $error("upper bits not zero");
  chk_behavior_upper: assert property (reg_rd && reg_addr == 8'h81 |=> reg_rdata[7:4] == 4'h0)
    else $error("behavior upper bits not zero");
  chk_drive_echo: assert property (reg_wr && reg_addr == 8'h74 ##1 reg_rd && reg_addr == 8'h74
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03)) else $error("drive readback wrong");
  chk_trans_echo: assert property (reg_wr && reg_addr == 8'h77 ##1 reg_rd && reg_addr == 8'h77
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03)) else $error("transition readback wrong");
  chk_mirror_echo: assert property (reg_wr && reg_addr == 8'h79 ##1 reg_rd && reg_addr == 8'h79
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03)) else $error("mirror readback wrong");
  chk_behavior_echo: assert property (reg_wr && reg_addr == 8'h81 ##1 reg_rd && reg_addr == 8'h81
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'h0F)) else $error("behavior readback wrong");
endmodule // ldc_properties
bind ldc_top ldc_properties i_props (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// file: tb/ldc_testbench.sv
// Purpose: self-checking bench for ldc_top
// Assumes: direct behavior, min duty 00, max duty FF
// Notes:   lamp waits are bounded polls
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
  reg        clk_sys   = 1'b0;
  reg        arst_n    = 1'b0;
  reg  [7:0] reg_addr  = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr    = 1'b0;
  reg        reg_rd    = 1'b0;
  reg  [1:0] touch     = 2'h0;
  reg  [7:0] b;
  wire [7:0] reg_rdata;
  wire       pin1;
  wire       pin2;
  wire [1:0] lamp_on;
  integer    mismatches = 0;
  integer    num_checks = 0;
  integer    cycles     = 0;
  always #5 clk_sys = ~clk_sys;
  ldc_top i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_touch_input(touch[0]), .second_touch_input(touch[1]),
    .first_lamp_pin(pin1), .second_lamp_pin(pin2));
  ldc_lamps i_lamps (.first_lamp_pin(pin1), .second_lamp_pin(pin2), .lamp_on(lamp_on));
  task summarize;
  begin
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      mismatches++;
      summarize;
    end
  end
  task xfer(input w, input r, input [7:0] a, input [7:0] d);
  begin
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    xfer(1'b1, 1'b0, a, d);
  endtask
  task chkrd(input [7:0] a, input [7:0] e);
  begin
    xfer(1'b0, 1'b1, a, 8'h00);
    xfer(1'b0, 1'b0, 8'h00, 8'h00);
    `CHK(reg_rdata, e)
  end
  endtask
  // h=0 waits for the level, h=1 demands it stays
  task lamp(input integer c, input e, input h);
    integer n;
  begin
    xfer(1'b0, 1'b0, 8'h00, 8'h00);
    n = 0;
    while (n < (h ? 3000 : 26000) && ((lamp_on[c] === e) == h))
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    `CHK(lamp_on[c], e)
  end
  endtask
  task t_reset;
  begin
    chkrd(8'h74, 8'h00);
    chkrd(8'h77, 8'h00);
    chkrd(8'h79, 8'h00);
    chkrd(8'h81, 8'h00);
    lamp(0, 1'b0, 1'b1);
  end
  endtask
  task t_regs;
  begin
    wr(8'h74, 8'hFE);
    chkrd(8'h74, 8'h02);
    wr(8'h77, 8'hFD);
    chkrd(8'h77, 8'h01);
    wr(8'h79, 8'hFE);
    chkrd(8'h79, 8'h02);
    wr(8'h81, 8'hF6);
    chkrd(8'h81, 8'h06);
    wr(8'h00, 8'hFF);
    chkrd(8'h00, 8'h00);
    wr(8'h81, 8'h00);
    wr(8'h74, 8'h00);
    wr(8'h77, 8'h00);
    wr(8'h79, 8'h00);
    for (b = 8'h00; b < 8'h10; b = b + 8'h05)
    begin
      wr(8'h81, 8'hF0 | b);
      chkrd(8'h81, b);
    end
    wr(8'h81, 8'h00);
  end
  endtask
  task t_mirror;
  begin
    wr(8'h88, 8'h00);
    wr(8'h73, 8'h03);
    chkrd(8'h79, 8'h03);
    wr(8'h88, 8'h02);
    wr(8'h73, 8'h00);
    chkrd(8'h79, 8'h03);
    wr(8'h88, 8'h00);
    wr(8'h73, 8'h00);
    chkrd(8'h79, 8'h00);
    wr(8'h73, 8'h01);
    lamp(0, 1'b0, 1'b1);
    wr(8'h74, 8'h01);
    lamp(0, 1'b1, 1'b0);
    wr(8'h79, 8'h00);
    lamp(0, 1'b0, 1'b0);
    wr(8'h73, 8'h00);
    lamp(0, 1'b1, 1'b0);
    wr(8'h74, 8'h00);
    lamp(0, 1'b0, 1'b0);
  end
  endtask
  task t_host;
  begin
    wr(8'h74, 8'h01);
    lamp(0, 1'b1, 1'b0);
    wr(8'h74, 8'h02);
    lamp(0, 1'b0, 1'b0);
    lamp(1, 1'b1, 1'b0);
    wr(8'h74, 8'h00);
    lamp(1, 1'b0, 1'b0);
  end
  endtask
  task t_link(input [7:0] tr, input [7:0] inv, input e_link, input e_touch);
  begin
    wr(8'h88, inv);
    wr(8'h77, tr);
    wr(8'h74, 8'h01);
    lamp(0, 1'b1, 1'b0);
    wr(8'h72, 8'h01);
    lamp(0, e_link, 1'b0);
    lamp(0, e_link, 1'b1);
    wr(8'h74, 8'h00);
    wr(8'h74, 8'h01);
    lamp(0, e_link, 1'b1);
    touch <= 2'h1;
    lamp(0, e_touch, 1'b0);
    lamp(0, e_touch, 1'b1);
    touch <= 2'h0;
    wr(8'h72, 8'h00);
    lamp(0, 1'b1, 1'b0);
  end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_regs;
    t_mirror;
    t_host;
    t_link(8'h00, 8'h00, 1'b0, 1'b1);
    t_link(8'h01, 8'h00, 1'b1, 1'b1);
    t_link(8'h01, 8'h01, 1'b1, 1'b0);
    summarize;
  end
endmodule // testbench
